// ===== logic/saop_pkg.sv
// constants shared by the converter output pipeline
// assumes one sample clock; no software-visible registers
package saop_pkg;

    localparam int COARSE_W = 5;
    localparam int FINE_W = 6;
    localparam int RESULT_W = 10;
    // half of the fine range overlaps the coarse step
    localparam logic [5:0] FINE_OFFSET = 6'h10;
    localparam logic [9:0] POS_FULL_SCALE = 10'h1FF;
    localparam logic [9:0] NEG_FULL_SCALE = 10'h200;
    localparam logic [11:0] OFFSET_MAX = 12'h3FF;
    // edges from capture to output latch
    localparam int LATENCY_EDGES = 3;
    localparam int FILL_EDGES = 4;
    localparam logic [2:0] FILL_DONE = 3'h3;
    localparam logic [2:0] FILL_RESET = 3'h0;
    localparam int CLK_PERIOD_PS = 10000;
    localparam int RECOVERY_PS = 3000;
    // longest time rounds down, but never below one cycle
    localparam int RECOVERY_CYCLES = (RECOVERY_PS / CLK_PERIOD_PS) < 1 ? 1 : (RECOVERY_PS / CLK_PERIOD_PS);
    localparam int MIN_RATE_MSPS = 40;

    typedef enum logic [1:0] {
        SAOP_FILL = 2'b01,
        SAOP_RUN = 2'b10
    } saop_fill_t;

endpackage

// ===== logic/saop_correct.sv
// overlap correction: coarse and fine estimates to one two's complement word
// assumes the fine stage spans twice a coarse step, centred on it
`timescale 1ns/10ps
module saop_correct #(
    parameter int COARSE_W = 5,
    parameter int FINE_W = 6,
    parameter int RESULT_W = 10
) (
    input wire logic [COARSE_W-1:0] coarse_i,
    input wire logic [FINE_W-1:0] fine_i,
    output logic [RESULT_W-1:0] word_o,
    output logic clip_high_o,
    output logic clip_low_o
);

    logic [11:0] sum;

    always_comb
    begin
        // offset binary; a slightly negative or overfull sum means stage mismatch at the span edges
        sum = {2'h0, coarse_i, 5'h00} + {6'h00, fine_i} - {6'h00, saop_pkg::FINE_OFFSET};
        clip_low_o = sum[11];
        clip_high_o = !sum[11] && (sum > saop_pkg::OFFSET_MAX);
        if (clip_low_o)
        begin
            word_o = saop_pkg::NEG_FULL_SCALE;
        end
        else if (clip_high_o)
        begin
            word_o = saop_pkg::POS_FULL_SCALE;
        end
        else
        begin
            // flipping the top bit turns offset binary into two's complement
            word_o = {~sum[9], sum[8:0]};
        end
    end

endmodule

// ===== logic/saop_pipeline.sv
// digital back end of a subranging sampling converter: capture, correction,
// saturation and a latched output three sample edges after capture
// assumes sys_clk_i is the sample clock and the quantiser outputs settle on it
`timescale 1ns/10ps
// Contract
// - each rising sample edge captures a new sample, held through its conversion.
// - five coarse and six fine bits merge, overlap corrected, into ten bits.
// - sample from edge N appears on the outputs after edge N+3.
// - output word is latched, changing only on rising sample edges.
// - range flag is high exactly when the sample lies outside the span.
// - out-of-span samples force 1FFh above span or 200h below.
// - once input returns inside span, conversion resumes within one cycle.
// - result bits are two's complement with bit nine the most significant.
module saop_pipeline #(
    parameter int COARSE_W = saop_pkg::COARSE_W,
    parameter int FINE_W = saop_pkg::FINE_W,
    parameter int RESULT_W = saop_pkg::RESULT_W
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [COARSE_W-1:0] coarse_code_i,
    input wire logic [FINE_W-1:0] fine_code_i,
    input wire logic above_span_i,
    input wire logic below_span_i,
    output logic [RESULT_W-1:0] result_bits_o,
    output logic range_flag_o,
    output logic data_valid_o
);

    // data stages carry no reset: they are flushed by clocking, as in the analog part
    logic [COARSE_W-1:0] cap_coarse_reg, cap_coarse_next;
    logic [FINE_W-1:0] cap_fine_reg, cap_fine_next;
    logic cap_above_reg, cap_above_next;
    logic cap_below_reg, cap_below_next;
    logic [RESULT_W-1:0] conv_word;
    logic clip_high, clip_low;
    logic [RESULT_W-1:0] sat_word_reg, sat_word_next;
    logic sat_flag_reg, sat_flag_next;
    logic [RESULT_W-1:0] mid_word_reg, mid_word_next;
    logic mid_flag_reg, mid_flag_next;
    logic [RESULT_W-1:0] out_word_reg, out_word_next;
    logic out_flag_reg, out_flag_next;
    saop_pkg::saop_fill_t fill_reg, fill_next;
    logic [2:0] fill_cnt_reg, fill_cnt_next;

    saop_correct #(
        .COARSE_W(COARSE_W),
        .FINE_W(FINE_W),
        .RESULT_W(RESULT_W)
    ) u_correct (
        .coarse_i(cap_coarse_reg),
        .fine_i(cap_fine_reg),
        .word_o(conv_word),
        .clip_high_o(clip_high),
        .clip_low_o(clip_low)
    );

    always_comb
    begin
        // a fresh sample every edge, frozen until the next one
        cap_coarse_next = coarse_code_i;
        cap_fine_next = fine_code_i;
        cap_above_next = above_span_i;
        cap_below_next = below_span_i;
        // comparators override the quantiser; above wins if both claim
        if (cap_above_reg)
        begin
            sat_word_next = saop_pkg::POS_FULL_SCALE;
        end
        else if (cap_below_reg)
        begin
            sat_word_next = saop_pkg::NEG_FULL_SCALE;
        end
        else
        begin
            // no memory of earlier samples, so recovery is the very next sample
            sat_word_next = conv_word;
        end
        sat_flag_next = cap_above_reg || cap_below_reg;
        mid_word_next = sat_word_reg;
        mid_flag_next = sat_flag_reg;
        out_word_next = mid_word_reg;
        out_flag_next = mid_flag_reg;
    end

    always_ff @(posedge sys_clk_i)
    begin
        cap_coarse_reg <= cap_coarse_next;
        cap_fine_reg <= cap_fine_next;
        cap_above_reg <= cap_above_next;
        cap_below_reg <= cap_below_next;
        sat_word_reg <= sat_word_next;
        sat_flag_reg <= sat_flag_next;
        mid_word_reg <= mid_word_next;
        mid_flag_reg <= mid_flag_next;
        // output latch only moves on the rising edge
        out_word_reg <= out_word_next;
        out_flag_reg <= out_flag_next;
    end

    // fill tracker: marks words that come from real samples after reset
    always_comb
    begin
        fill_next = fill_reg;
        fill_cnt_next = fill_cnt_reg;
        unique case (fill_reg)
            saop_pkg::SAOP_FILL:
            begin
                fill_cnt_next = fill_cnt_reg + 3'h1;
                if (fill_cnt_reg == saop_pkg::FILL_DONE)
                begin
                    fill_next = saop_pkg::SAOP_RUN;
                end
            end
            saop_pkg::SAOP_RUN:
            begin
                fill_cnt_next = fill_cnt_reg;
            end
            default:
            begin
                fill_next = saop_pkg::SAOP_FILL;
                fill_cnt_next = saop_pkg::FILL_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            fill_reg <= saop_pkg::SAOP_FILL;
            fill_cnt_reg <= saop_pkg::FILL_RESET;
        end
        else
        begin
            fill_reg <= fill_next;
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // two's complement, bit nine the sign
    assign result_bits_o = out_word_reg;
    assign range_flag_o = out_flag_reg;
    assign data_valid_o = (fill_reg == saop_pkg::SAOP_RUN);

    // checks only look at words that stem from real samples
    logic chk_off;
    logic [11:0] ob_sum;
    assign chk_off = srst_i || !data_valid_o;
    assign ob_sum = {2'h0, cap_coarse_reg, 5'h00} + {6'h00, cap_fine_reg} - {6'h00, saop_pkg::FINE_OFFSET};

    capture_freeze_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        cap_coarse_reg == $past(coarse_code_i) && cap_fine_reg == $past(fine_code_i))
        else $error("captured sample differs from inputs at the edge");

    overlap_merge_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        (!ob_sum[11] && ob_sum <= 12'h3FF) |-> conv_word == {~ob_sum[9], ob_sum[8:0]})
        else $error("corrected word does not match coarse and fine sum");

    // the word sampled here left the correction stage three edges ago
    three_edge_latency_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        !$past(cap_above_reg, 3) && !$past(cap_below_reg, 3) |-> result_bits_o == $past(conv_word, 3))
        else $error("output word not from the sample three edges back");

    output_hold_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        result_bits_o == $past(mid_word_reg) && $stable(result_bits_o) == ($past(mid_word_reg) == $past(result_bits_o)))
        else $error("output latch changed without a new word");

    flag_match_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        range_flag_o == ($past(above_span_i, 4) || $past(below_span_i, 4)))
        else $error("range flag disagrees with the sample it marks");

    sat_high_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        $past(above_span_i, 4) |-> result_bits_o == 10'h1FF && range_flag_o)
        else $error("above-span sample not forced to positive full scale");

    sat_low_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        !$past(above_span_i, 4) && $past(below_span_i, 4) |-> result_bits_o == 10'h200 && range_flag_o)
        else $error("below-span sample not forced to negative full scale");

    span_recover_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        $rose(cap_above_reg) ##1 !cap_above_reg && !cap_below_reg |-> ##3 !range_flag_o)
        else $error("no recovery on the first in-span sample");

    sign_bit_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        $past(sat_flag_reg, 2) == 1'b0 && $past(ob_sum, 3) < 12'h200 |-> result_bits_o[9])
        else $error("lower half of span not negative in two's complement");

    // fixed point of the overlap: mid-scale coarse plus the offset fine code is zero
    mid_scale_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        cap_coarse_reg == 5'h10 && cap_fine_reg == 6'h10 |-> conv_word == 10'h000)
        else $error("mid-scale sample not coded as zero");

    // a raised flag always stands beside a saturated word of the same sample
    flag_word_pair_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
        range_flag_o |-> (result_bits_o == saop_pkg::POS_FULL_SCALE || result_bits_o == saop_pkg::NEG_FULL_SCALE))
        else $error("range flag beside a word that is not full scale");

    // once filled, only a new reset may drop the valid marker
    valid_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        data_valid_o |=> data_valid_o)
        else $error("valid marker dropped without a reset");

    fill_count_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $fell(srst_i) |-> !data_valid_o [*4] ##1 data_valid_o)
        else $error("valid marker not raised on the fourth edge");

    cover_over_span_c: cover property (@(posedge sys_clk_i) disable iff (chk_off)
        range_flag_o && result_bits_o == 10'h1FF);
    cover_under_span_c: cover property (@(posedge sys_clk_i) disable iff (chk_off)
        range_flag_o && result_bits_o == 10'h200);
    cover_clip_c: cover property (@(posedge sys_clk_i) disable iff (chk_off)
        clip_high || clip_low);
    cover_recover_c: cover property (@(posedge sys_clk_i) disable iff (chk_off)
        range_flag_o ##1 !range_flag_o);
    cover_fill_done_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        !data_valid_o ##1 data_valid_o);

endmodule

// ===== verification/saop_capture.sv
// capture-side model: latches the converter outputs and flags usable words
// assumes the bench supplies the sample clock and the reset that stops it
`timescale 1ns/10ps
module saop_capture (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [9:0] result_bits_i,
    input wire logic range_flag_i,
    output logic [9:0] word_o,
    output logic flag_o,
    output logic ok_o
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    always_comb
    begin
        cnt_next = cnt_reg;
        if (srst_i)
            cnt_next = 3'h0;
        else if (cnt_reg != 3'h4)
            cnt_next = cnt_reg + 3'h1;
    end
    always_ff @(posedge sys_clk_i)
    begin
        cnt_reg <= cnt_next;
        word_o <= result_bits_i;
        flag_o <= range_flag_i;
    end
    // words before the fourth edge after a restart are pipeline junk
    assign ok_o = (cnt_reg == 3'h4);
endmodule

// ===== verification/saop_pipeline_tb.sv
// self-checking bench for the converter output pipeline
// assumes saop_pkg, the design and saop_capture are compiled first
`timescale 1ns/10ps
module saop_pipeline_tb;
    logic sys_clk_i;
    logic srst_i;
    logic [4:0] coarse;
    logic [5:0] fine;
    logic above;
    logic below;
    logic [9:0] result;
    logic flag;
    logic valid;
    logic cap_ok;
    int n_mismatch;
    int samples_checked;
    logic [10:0] expq[$];

    // 100 MHz keeps the sample rate above the 40 MSPS floor
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    saop_pipeline i_saop_pipeline (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .coarse_code_i(coarse),
        .fine_code_i(fine), .above_span_i(above), .below_span_i(below), .result_bits_o(result),
        .range_flag_o(flag), .data_valid_o(valid));
    saop_capture i_saop_capture (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .result_bits_i(result),
        .range_flag_i(flag), .word_o(), .flag_o(), .ok_o(cap_ok));

    task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // offset-binary sum, clamped, MSB flipped; comparators override
    function automatic logic [10:0] model(input logic [4:0] c, input logic [5:0] f, input logic a, input logic b);
        int s;
        logic [9:0] w;
        s = int'(c) * 32 + int'(f) - 16;
        if (s < 0)
            s = 0;
        if (s > 1023)
            s = 1023;
        w = 10'(s) ^ 10'h200;
        if (a)
            w = saop_pkg::POS_FULL_SCALE;
        else if (b)
            w = saop_pkg::NEG_FULL_SCALE;
        return {a | b, w};
    endfunction

    // inputs set here are taken at the next edge and due four steps later
    task automatic step(input logic [4:0] c, input logic [5:0] f, input logic a, input logic b);
        logic [10:0] e;
        @(posedge sys_clk_i);
        coarse <= c;
        fine <= f;
        above <= a;
        below <= b;
        expq.push_back(model(c, f, a, b));
        if (expq.size() == 5)
        begin
            e = expq.pop_front();
            #1;
            chk_word(result, e[9:0]);
            chk_bit(flag, e[10]);
            @(negedge sys_clk_i);
            chk_word(result, e[9:0]);
        end
    endtask

    task automatic drain();
        repeat (4) step(5'h10, 6'h10, 1'b0, 1'b0);
    endtask

    task automatic codes();
        step(5'h10, 6'h10, 1'b0, 1'b0);
        step(5'h10, 6'h11, 1'b0, 1'b0);
        step(5'h0F, 6'h3F, 1'b0, 1'b0);
        step(5'h00, 6'h10, 1'b0, 1'b0);
        step(5'h00, 6'h00, 1'b0, 1'b0);
        step(5'h1F, 6'h2F, 1'b0, 1'b0);
        step(5'h1F, 6'h3F, 1'b0, 1'b0);
        step(5'h0A, 6'h05, 1'b0, 1'b0);
        drain();
    endtask

    task automatic range_cases();
        step(5'h03, 6'h21, 1'b1, 1'b0);
        step(5'h1C, 6'h02, 1'b0, 1'b1);
        step(5'h07, 6'h07, 1'b1, 1'b1);
        step(5'h12, 6'h30, 1'b0, 1'b0);
        step(5'h05, 6'h1A, 1'b0, 1'b1);
        step(5'h05, 6'h1A, 1'b0, 1'b0);
        drain();
    endtask

    task automatic reset_fill();
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        for (int i = 1; i <= 4; i++)
        begin
            @(posedge sys_clk_i);
            #1;
            chk_bit(valid, i == 4);
            chk_bit(cap_ok, i == 4);
        end
        expq.delete();
    endtask

    task automatic close_out();
        $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #50000;
        n_mismatch++;
        close_out();
    end

    initial
    begin
        srst_i = 1'b1;
        coarse = 5'h10;
        fine = 6'h10;
        above = 1'b0;
        below = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (6) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        codes();
        range_cases();
        reset_fill();
        codes();
        close_out();
    end
endmodule
